// *** design/spim_regs.sv ***
// parameter registers, index multiplexers and recording statistics
`timescale 1ns/1ps
module spim_regs
	import spim_pkg::*;
#(
	parameter int DEPTH = MAX_SAMPLES,
	parameter int ADC_W = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// converter samples and trigger input (pins)
	input wire logic [ADC_W-1:0] adc_sample,
	input wire logic trigger_in,
	// process data words
	input wire logic [15:0] output_word_zero,
	input wire logic output_word_zero_valid,
	input wire logic [15:0] output_word_one,
	input wire logic output_word_one_valid,
	output logic [15:0] input_word_zero,
	// parameter writes toward the trigger units
	output spim_param_wr_t param_wr,
	// threshold level 1 from trigger unit 1
	input wire logic [15:0] threshold_one,
	// acquisition status
	output logic recording,
	output logic fast_mode
);
	initial begin
		if (DEPTH < 2 || DEPTH > MAX_SAMPLES)
			$error("spim_regs: DEPTH out of range");
		if (ADC_W != 16)
			$error("spim_regs: ADC_W must be 16");
	end

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic out_index_ok(input logic [7:0] ix);
		return ix == OIX_DEFAULT ||
			(ix >= OIX_TU1_FIRST && ix <= OIX_TU1_LAST) ||
			(ix >= OIX_TU2_FIRST && ix <= OIX_TU2_LAST);
	endfunction : out_index_ok

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = d[7:0];
		if (sel[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : merge

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [ADC_W-1:0] adc_meta, adc_live;
	logic trig_meta, trig_sync, trig_last;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			adc_meta <= '0;
			adc_live <= '0;
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
			trig_last <= 1'b0;
		end else begin
			adc_meta <= adc_sample;
			adc_live <= adc_meta;
			trig_meta <= trigger_in;
			trig_sync <= trig_meta;
			trig_last <= trig_sync;
		end
	end

	// ----------------------------------------------------------------
	// register file and bus
	// ----------------------------------------------------------------
	logic [15:0] user_offset, user_gain, sample_interval, sample_count;
	logic [15:0] output_param_index, input_datum_index, mode;
	logic [15:0] next_user_offset, next_user_gain, next_sample_interval;
	logic [15:0] next_sample_count, next_output_param_index;
	logic [15:0] next_input_datum_index, next_mode;
	logic [31:0] next_wb_dat_o;
	logic next_wb_ack_o;
	logic [7:0] widx;
	logic wr;

	always_comb begin
		widx = wb_adr_i[ADDR_LSB +: 8];
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
		next_user_offset = user_offset;
		next_user_gain = user_gain;
		next_sample_interval = sample_interval;
		next_sample_count = sample_count;
		next_output_param_index = output_param_index;
		next_input_datum_index = input_datum_index;
		next_mode = mode;
		next_wb_ack_o = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_wb_dat_o = '0;
		if (wr) begin
			unique case (widx)
				REG_USER_OFFSET:
					next_user_offset = merge(user_offset, wb_dat_i, wb_sel_i);
				REG_USER_GAIN:
					next_user_gain = merge(user_gain, wb_dat_i, wb_sel_i);
				REG_SAMPLE_INTERVAL:
					next_sample_interval =
						merge(sample_interval, wb_dat_i, wb_sel_i);
				REG_SAMPLE_COUNT:
					next_sample_count = merge(sample_count, wb_dat_i, wb_sel_i);
				REG_OUTPUT_PARAM_INDEX:
					next_output_param_index =
						merge(output_param_index, wb_dat_i, wb_sel_i);
				REG_INPUT_DATUM_INDEX:
					next_input_datum_index =
						merge(input_datum_index, wb_dat_i, wb_sel_i);
				REG_MODE:
					next_mode = merge(mode, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
		unique case (widx)
			REG_USER_OFFSET: next_wb_dat_o[15:0] = user_offset;
			REG_USER_GAIN: next_wb_dat_o[15:0] = user_gain;
			REG_SAMPLE_INTERVAL: next_wb_dat_o[15:0] = sample_interval;
			REG_SAMPLE_COUNT: next_wb_dat_o[15:0] = sample_count;
			REG_OUTPUT_PARAM_INDEX: next_wb_dat_o[15:0] = output_param_index;
			REG_INPUT_DATUM_INDEX: next_wb_dat_o[15:0] = input_datum_index;
			REG_MODE: next_wb_dat_o[15:0] = mode;
			REG_STATUS: next_wb_dat_o[15:0] = {14'h0000, fast_mode, recording};
			default: next_wb_dat_o = '0;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			user_offset <= RST_ZERO;
			user_gain <= RST_ZERO;
			sample_interval <= RST_SAMPLE_INTERVAL;
			sample_count <= RST_SAMPLE_COUNT;
			output_param_index <= RST_ZERO;
			input_datum_index <= RST_INPUT_INDEX;
			mode <= RST_ZERO;
			wb_dat_o <= '0;
			wb_ack_o <= 1'b0;
		end else begin
			user_offset <= next_user_offset;
			user_gain <= next_user_gain;
			sample_interval <= next_sample_interval;
			sample_count <= next_sample_count;
			output_param_index <= next_output_param_index;
			input_datum_index <= next_input_datum_index;
			mode <= next_mode;
			wb_dat_o <= next_wb_dat_o;
			wb_ack_o <= next_wb_ack_o;
		end
	end

	// ----------------------------------------------------------------
	// acquisition timing and recording
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ACQ_IDLE, ACQ_WAIT, ACQ_RUN} spim_acq_t;
	spim_acq_t acq, next_acq;
	logic is_fast, start_req;
	logic [15:0] interval_eff, count_eff, us_left, next_us_left;
	logic [15:0] n_done, next_n_done;
	logic [4:0] tick, next_tick;
	logic take;
	logic signed [15:0] corrected;
	logic signed [31:0] off_scaled;
	logic [15:0] mem [DEPTH];

	always_comb begin
		is_fast = mode[MODE_TTYPE_LSB +: 3] == TTYPE_FAST;
		if (is_fast)
			interval_eff = sample_interval < 16'(MIN_FAST_INTERVAL_US) ?
				16'(MIN_FAST_INTERVAL_US) : sample_interval;
		else
			interval_eff = sample_interval < 16'(MIN_INTERVAL_US) ?
				16'(MIN_INTERVAL_US) : sample_interval;
		count_eff = sample_count > 16'(DEPTH) ? 16'(DEPTH) :
			(sample_count == 16'h0000 ? 16'h0001 : sample_count);
		// fast mode arms only on the trigger input edge; a write that
		// switches into fast mode must not start a register recording
		start_req = is_fast ? (trig_sync && !trig_last)
			: (wr && widx == REG_MODE && wb_dat_i[MODE_RUN_BIT]
			&& next_mode[MODE_TTYPE_LSB +: 3] != TTYPE_FAST);
		// full scale taken as the converter word: offset*fs/res ~ offset
		off_scaled = 32'(signed'(user_offset)) * 32'sh00007FFF / 32'sh00007FFF;
		corrected = signed'(adc_live) + 16'(off_scaled);
		take = 1'b0;
		next_tick = tick;
		next_us_left = us_left;
		next_n_done = n_done;
		next_acq = acq;
		unique case (acq)
			ACQ_IDLE: begin
				if (start_req) begin
					next_acq = ACQ_RUN;
					next_n_done = '0;
					next_us_left = '0;
					next_tick = '0;
				end
			end
			ACQ_WAIT, ACQ_RUN: begin
				if (tick == 5'(CYCLES_PER_US - 1)) begin
					next_tick = '0;
					if (us_left == '0) begin
						take = 1'b1;
						next_us_left = interval_eff - 16'h0001;
						next_n_done = n_done + 16'h0001;
						if (n_done + 16'h0001 == count_eff)
							next_acq = ACQ_IDLE;
					end else
						next_us_left = us_left - 16'h0001;
				end else
					next_tick = tick + 5'h01;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acq <= ACQ_IDLE;
			tick <= '0;
			us_left <= '0;
			n_done <= '0;
			recording <= 1'b0;
			fast_mode <= 1'b0;
		end else begin
			acq <= next_acq;
			tick <= next_tick;
			us_left <= next_us_left;
			n_done <= next_n_done;
			recording <= next_acq != ACQ_IDLE;
			fast_mode <= is_fast;
		end
	end

	always_ff @(posedge clock) begin
		if (take)
			mem[n_done[AW-1:0]] <= corrected;
	end

	// ----------------------------------------------------------------
	// statistics over the recording
	// ----------------------------------------------------------------
	spim_stats_t st, next_st;
	logic [47:0] sum_sq, next_sum_sq;
	logic signed [31:0] sum, next_sum;
	logic [2:0] run_hi, run_lo, next_run_hi, next_run_lo;
	logic level_hi, next_level_hi;
	logic [15:0] pw_cnt, next_pw_cnt;
	logic seen_above, seen_below, next_seen_above, next_seen_below;
	logic sq_start;
	logic [15:0] root;
	logic root_done;

	always_comb begin
		next_st = st;
		next_sum = sum;
		next_sum_sq = sum_sq;
		next_run_hi = run_hi;
		next_run_lo = run_lo;
		next_level_hi = level_hi;
		next_pw_cnt = pw_cnt;
		next_seen_above = seen_above;
		next_seen_below = seen_below;
		sq_start = 1'b0;
		if (start_req && acq == ACQ_IDLE) begin
			next_st = '0;
			next_st.vmin = 16'h7FFF;
			next_st.vmax = 16'h8000;
			next_sum = '0;
			next_sum_sq = '0;
			next_run_hi = '0;
			next_run_lo = '0;
			next_pw_cnt = '0;
			next_seen_above = 1'b0;
			next_seen_below = 1'b0;
		end else if (take) begin
			if (corrected > signed'(st.vmax))
				next_st.vmax = corrected;
			if (corrected < signed'(st.vmin))
				next_st.vmin = corrected;
			next_sum = sum + 32'(corrected);
			next_sum_sq = sum_sq + 48'(32'(corrected) * 32'(corrected));
			if (corrected > signed'(threshold_one)) begin
				next_run_hi = run_hi == 3'(PULSE_RUN) ? run_hi : run_hi + 3'h1;
				next_run_lo = '0;
				if (!seen_above)
					next_st.first_above = n_done;
				next_seen_above = 1'b1;
			end else begin
				next_run_lo = run_lo == 3'(PULSE_RUN) ? run_lo : run_lo + 3'h1;
				next_run_hi = '0;
				if (!seen_below)
					next_st.first_below = n_done;
				next_seen_below = 1'b1;
			end
			next_pw_cnt = pw_cnt + 16'h0001;
			// four in a row flips the level and closes the other pulse
			if (next_run_hi == 3'(PULSE_RUN) && !level_hi) begin
				next_level_hi = 1'b1;
				next_st.pw_low = pw_cnt;
				next_pw_cnt = '0;
			end else if (next_run_lo == 3'(PULSE_RUN) && level_hi) begin
				next_level_hi = 1'b0;
				next_st.pw_high = pw_cnt;
				next_pw_cnt = '0;
			end
			if (next_acq == ACQ_IDLE) begin
				next_st.mean = 16'(next_sum / signed'(32'(count_eff)));
				sq_start = 1'b1;
			end
		end
		if (root_done)
			next_st.rms = root;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '0;
			sum <= '0;
			sum_sq <= '0;
			run_hi <= '0;
			run_lo <= '0;
			level_hi <= 1'b0;
			pw_cnt <= '0;
			seen_above <= 1'b0;
			seen_below <= 1'b0;
		end else begin
			st <= next_st;
			sum <= next_sum;
			sum_sq <= next_sum_sq;
			run_hi <= next_run_hi;
			run_lo <= next_run_lo;
			level_hi <= next_level_hi;
			pw_cnt <= next_pw_cnt;
			seen_above <= next_seen_above;
			seen_below <= next_seen_below;
		end
	end

	spim_isqrt #(.W(32)) u_sqrt (
		.clock(clock),
		.rst(rst),
		.start(sq_start),
		.radicand(32'(next_sum_sq / 48'(count_eff))),
		.root(root),
		.done(root_done)
	);

	// ----------------------------------------------------------------
	// process data multiplexers
	// ----------------------------------------------------------------
	spim_param_wr_t next_param_wr;
	logic [15:0] next_input_word_zero, trace_ix;
	logic [7:0] ix_lo, ix_hi;

	always_comb begin
		ix_lo = output_param_index[7:0];
		ix_hi = output_param_index[15:8];
		next_param_wr = '0;
		// index is the target register number; unsupported codes drop
		if (output_word_zero_valid && out_index_ok(ix_lo)) begin
			next_param_wr.strobe = ix_lo != OIX_DEFAULT;
			next_param_wr.index = ix_lo;
			next_param_wr.value = output_word_zero;
		end else if (output_word_one_valid && out_index_ok(ix_hi)) begin
			next_param_wr.strobe = ix_hi != OIX_DEFAULT;
			next_param_wr.index = ix_hi;
			next_param_wr.value = output_word_one;
		end
		trace_ix = {1'b0, input_datum_index[14:0]};
		next_input_word_zero = '0;
		if (input_datum_index[IIX_TRACE_BIT]) begin
			if (trace_ix < 16'(DEPTH))
				next_input_word_zero = mem[trace_ix[AW-1:0]];
		end else begin
			unique case (input_datum_index)
				IIX_LIVE: next_input_word_zero = corrected;
				IIX_MAX: next_input_word_zero = st.vmax;
				IIX_MIN: next_input_word_zero = st.vmin;
				IIX_RMS: next_input_word_zero = st.rms;
				IIX_MEAN: next_input_word_zero = st.mean;
				IIX_PP: next_input_word_zero = st.vmax - st.vmin;
				IIX_CYCLE:
					next_input_word_zero = st.pw_high + st.pw_low;
				IIX_PW_HIGH: next_input_word_zero = st.pw_high;
				IIX_PW_LOW: next_input_word_zero = st.pw_low;
				IIX_MARK_SPACE: next_input_word_zero = st.pw_low == '0 ?
					16'h0000 : st.pw_high / st.pw_low;
				IIX_HISTO: next_input_word_zero = st.mean;
				IIX_ENV_INNER, IIX_ENV_OUTER:
					next_input_word_zero = 16'h0000;
				IIX_FIRST_ABOVE: next_input_word_zero = st.first_above;
				IIX_FIRST_BELOW: next_input_word_zero = st.first_below;
				default: next_input_word_zero = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			param_wr <= '0;
			input_word_zero <= '0;
		end else begin
			param_wr <= next_param_wr;
			input_word_zero <= next_input_word_zero;
		end
	end
endmodule : spim_regs

// *** design/spim_pkg.sv ***
// package: register map, field layouts, index codes and timing for spim
//
// Overview of operation
// - sample interval is spacing between acquisitions, in microseconds
// - normal mode never samples faster than once per 100 us
// - only high-rate capture mode allows intervals down to 10 us
// - sample count sets samples per recording; default 100, at most 4000
// - output index low byte picks parameter written by output word zero
// - output index high byte picks parameter for output word one, same codes
// - output index value is the register number of the written parameter
// - indices 0x00, 0x29-0x2C, 0x2F-0x32 supported for trigger units
// - input index picks datum of input word zero; reset 0 = live value
// - indices 1..5 give max, min, rms, mean, peak-to-peak of recording
// - mean is sum over count; rms is root of squared sum over count
// - index 7: high pulse width, four samples above start, four below stop
// - index 8: low pulse width, four below start, four above stop
// - index 6 cycle duration, 9 mark/space ratio, 0x0D histogram maximum; 0x0D here returns the mean
// - index 0x12 inner envelope errors, 0x13 outer envelope errors; here both always read as 0
// - index 0x14/0x15 samples until first above/below threshold 1
// - indices from 0x8000 return stored samples; top bit cleared gives offset
// - user offset applied as full scale times parameter over resolution
// - trigger type 011 selects high-rate mode: trigger input only, channel 1
package spim_pkg;
	// ----------------------------------------------------------------
	// register map (word index; byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_USER_OFFSET = 8'h21;
	localparam logic [7:0] REG_USER_GAIN = 8'h22;
	localparam logic [7:0] REG_SAMPLE_INTERVAL = 8'h23;
	localparam logic [7:0] REG_SAMPLE_COUNT = 8'h24;
	localparam logic [7:0] REG_OUTPUT_PARAM_INDEX = 8'h25;
	localparam logic [7:0] REG_INPUT_DATUM_INDEX = 8'h26;
	localparam logic [7:0] REG_MODE = 8'h27;
	localparam logic [7:0] REG_STATUS = 8'h28;
	localparam int ADDR_LSB = 2;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_SAMPLE_COUNT = 16'h0064;
	localparam logic [15:0] RST_INPUT_INDEX = 16'h0000;
	localparam logic [15:0] RST_SAMPLE_INTERVAL = 16'h0064;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam int MAX_SAMPLES = 4000;
	localparam int MIN_INTERVAL_US = 100;
	localparam int MIN_FAST_INTERVAL_US = 10;
	localparam int CLOCK_MHZ = 25;
	localparam int CYCLES_PER_US = CLOCK_MHZ;
	localparam int PULSE_RUN = 4;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int MODE_TTYPE_LSB = 8;
	localparam logic [2:0] TTYPE_FAST = 3'h3;
	localparam int MODE_RUN_BIT = 0;

	// ----------------------------------------------------------------
	// output parameter index codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OIX_DEFAULT = 8'h00;
	localparam logic [7:0] OIX_TU1_FIRST = 8'h29;
	localparam logic [7:0] OIX_TU1_LAST = 8'h2C;
	localparam logic [7:0] OIX_TU2_FIRST = 8'h2F;
	localparam logic [7:0] OIX_TU2_LAST = 8'h32;
	localparam logic [7:0] OIX_TU2_BASE = 8'h2B;

	// ----------------------------------------------------------------
	// input datum index codes
	// ----------------------------------------------------------------
	localparam logic [15:0] IIX_LIVE = 16'h0000;
	localparam logic [15:0] IIX_MAX = 16'h0001;
	localparam logic [15:0] IIX_MIN = 16'h0002;
	localparam logic [15:0] IIX_RMS = 16'h0003;
	localparam logic [15:0] IIX_MEAN = 16'h0004;
	localparam logic [15:0] IIX_PP = 16'h0005;
	localparam logic [15:0] IIX_CYCLE = 16'h0006;
	localparam logic [15:0] IIX_PW_HIGH = 16'h0007;
	localparam logic [15:0] IIX_PW_LOW = 16'h0008;
	localparam logic [15:0] IIX_MARK_SPACE = 16'h0009;
	localparam logic [15:0] IIX_HISTO = 16'h000D;
	localparam logic [15:0] IIX_ENV_INNER = 16'h0012;
	localparam logic [15:0] IIX_ENV_OUTER = 16'h0013;
	localparam logic [15:0] IIX_FIRST_ABOVE = 16'h0014;
	localparam logic [15:0] IIX_FIRST_BELOW = 16'h0015;
	localparam int IIX_TRACE_BIT = 15;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} spim_wb_req_t;

	typedef struct packed {
		logic [15:0] value;
		logic [7:0] index;
		logic strobe;
	} spim_param_wr_t;

	typedef struct packed {
		logic [15:0] vmax;
		logic [15:0] vmin;
		logic [15:0] mean;
		logic [15:0] rms;
		logic [15:0] pw_high;
		logic [15:0] pw_low;
		logic [15:0] first_above;
		logic [15:0] first_below;
	} spim_stats_t;
endpackage : spim_pkg

// *** design/spim_isqrt.sv ***
// iterative integer square root, one result bit per clock
`timescale 1ns/1ps
module spim_isqrt
	import spim_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// operand and result
	input wire logic start,
	input wire logic [W-1:0] radicand,
	output logic [W/2-1:0] root,
	output logic done
);
	initial begin
		if (W < 2 || W % 2 != 0)
			$error("spim_isqrt: W must be even and at least 2");
	end

	localparam int SW = $clog2(W/2 + 1);
	logic [W/2-1:0] res, next_res;
	logic [W-1:0] rad, next_rad;
	logic [SW-1:0] step, next_step;
	logic busy, next_busy, next_done;
	logic [W/2-1:0] trial;

	always_comb begin
		trial = res | (W/2)'(1) << (step - SW'(1));
		next_res = res;
		next_rad = rad;
		next_step = step;
		next_busy = busy;
		next_done = 1'b0;
		if (start) begin
			next_res = '0;
			next_rad = radicand;
			next_step = SW'(W/2);
			next_busy = 1'b1;
		end else if (busy) begin
			if ({{(W/2){1'b0}}, trial} * {{(W/2){1'b0}}, trial} <= (2*W)'(rad))
				next_res = trial;
			next_step = step - SW'(1);
			if (step == SW'(1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			res <= '0;
			rad <= '0;
			step <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			res <= next_res;
			rad <= next_rad;
			step <= next_step;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign root = res;
endmodule : spim_isqrt

// *** testbench/spim_regs_assertions.sv ***
// checker for bus handshake and process-word writes of spim_regs
`timescale 1ns/1ps
module spim_regs_assertions
	import spim_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// process words
	input wire logic [15:0] output_word_zero,
	input wire logic output_word_zero_valid,
	input wire logic [15:0] output_word_one,
	input wire logic output_word_one_valid,
	input wire spim_param_wr_t param_wr
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("no ack after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_read_upper: assert property (wb_ack_o && !wb_we_i
		|-> wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
	a_write_cause: assert property (param_wr.strobe
		|-> $past(output_word_zero_valid || output_word_one_valid))
		else $error("parameter write without word");
	a_word_zero_val: assert property (param_wr.strobe
		&& $past(output_word_zero_valid)
		|-> param_wr.value == $past(output_word_zero))
		else $error("word zero value lost");
	a_word_one_val: assert property (param_wr.strobe
		&& $past(output_word_one_valid && !output_word_zero_valid)
		|-> param_wr.value == $past(output_word_one))
		else $error("word one value lost");
	a_index_known: assert property (param_wr.strobe
		|-> param_wr.index inside {[8'h29:8'h2C], [8'h2F:8'h32]})
		else $error("unsupported parameter index");
endmodule : spim_regs_assertions
bind spim_regs spim_regs_assertions spim_regs_assertions_i (.clock, .rst,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .output_word_zero,
	.output_word_zero_valid, .output_word_one, .output_word_one_valid,
	.param_wr);

// *** testbench/spim_coupler.sv ***
// coupler model: sends one process output word per bus cycle
`timescale 1ns/1ps
module spim_coupler #(
	parameter int GAP = 6
) (
	// clock
	input wire logic clock,
	// process output words toward the terminal
	output logic [15:0] word_zero,
	output logic zero_valid,
	output logic [15:0] word_one,
	output logic one_valid
);
	initial begin
		word_zero = 16'h0000;
		word_one = 16'h0000;
		zero_valid = 1'h0;
		one_valid = 1'h0;
	end
	// real bus cycles last milliseconds; GAP stands in for that spacing
	task automatic put(logic one, logic [15:0] v);
		word_zero <= one ? ~v : v;
		word_one <= one ? v : ~v;
		zero_valid <= !one;
		one_valid <= one;
		@(posedge clock);
		word_zero <= ~word_zero;
		word_one <= ~word_one;
		zero_valid <= 1'h0;
		one_valid <= 1'h0;
		repeat (GAP) @(posedge clock);
	endtask : put
endmodule : spim_coupler

// *** testbench/spim_regs_tb.sv ***
// self-checking bench for spim_regs driven through a coupler model
`timescale 1ns/1ps
module spim_regs_tb
	import spim_pkg::*;
;
	localparam int DEPTH = 16;
	logic clock = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic trig = 1'h0, ack, rec, fast, v0, v1;
	logic [3:0] sel = 4'h3;
	logic [9:0] adr = 10'h000;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [15:0] adc = 16'h0, thr = 16'h2000, lf = 16'h1229;
	logic [15:0] w0, w1, iw, a, b;
	logic [15:0] s[DEPTH];
	logic [23:0] wq[$], eq[$];
	logic [7:0] code[8] = '{8'h29, 8'h2A, 8'h2B, 8'h2C,
		8'h2F, 8'h30, 8'h31, 8'h32};
	longint sum, sq, mx, mn, q;
	int error_cnt = 0, samples_checked = 0, n, fa, fb;
	spim_param_wr_t pw;
	spim_regs #(.DEPTH(DEPTH)) spim_regs_i (.clock, .rst, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.adc_sample(adc), .trigger_in(trig), .output_word_zero(w0),
		.output_word_zero_valid(v0), .output_word_one(w1),
		.output_word_one_valid(v1), .input_word_zero(iw), .param_wr(pw),
		.threshold_one(thr), .recording(rec), .fast_mode(fast));
	spim_coupler spim_coupler_i (.clock, .word_zero(w0), .zero_valid(v0),
		.word_one(w1), .one_valid(v1));
	initial begin
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (pw.strobe === 1'h1) wq.push_back({pw.index, pw.value});
	end
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd
	task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
		samples_checked++;
		if (v !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic bus(logic w, logic [7:0] ix, logic [15:0] d);
		int t;
		t = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {ix, 2'h0};
		wdat <= {16'h0, d};
		do begin
			@(posedge clock);
			t++;
			if (t > 20) begin
				chk("ack_wait", 1, 0);
				test_done();
			end
		end while (ack !== 1'h1);
		r = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clock);
	endtask : bus
	task automatic wr(logic [7:0] ix, logic [15:0] d);
		bus(1'h1, ix, d);
	endtask : wr
	task automatic rd(string nm, logic [7:0] ix, logic [31:0] e);
		bus(1'h0, ix, 16'h0);
		chk(nm, e, r);
	endtask : rd
	task automatic chkix(string nm, logic [15:0] ix, logic [31:0] e);
		wr(REG_INPUT_DATUM_INDEX, ix);
		repeat (3) @(posedge clock);
		chk(nm, e, {16'h0, iw});
	endtask : chkix
	task automatic wait_rec(logic v, int lim);
		n = 0;
		while (rec !== v) begin
			@(posedge clock);
			n++;
			if (n > lim) begin
				chk("rec_wait", 1, 0);
				test_done();
			end
		end
	endtask : wait_rec
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		for (int i = 0; i < 6; i++) begin
			rd("reset", 8'(8'h21 + i),
				(i == 2 || i == 3) ? 32'h64 : 32'h0);
		end
		wr(8'h3F, rnd());
		rd("unmapped", 8'h3F, 32'h0);
		for (int i = 0; i < 3; i++) begin
			a = rnd();
			wr(8'(REG_USER_OFFSET + i), a);
			rd("rw", 8'(REG_USER_OFFSET + i), {16'h0, a});
		end
		for (int i = 0; i < 8; i++) begin
			wr(REG_OUTPUT_PARAM_INDEX, {code[7 - i], code[i]});
			a = rnd();
			b = rnd();
			eq.push_back({code[i], a});
			eq.push_back({code[7 - i], b});
			spim_coupler_i.put(1'h0, a);
			spim_coupler_i.put(1'h1, b);
		end
		// index zero is the default: a word sent then must write nothing
		wr(REG_OUTPUT_PARAM_INDEX, 16'h0000);
		spim_coupler_i.put(1'h0, rnd());
		chk("writes", eq.size(), wq.size());
		while (eq.size() > 0 && wq.size() > 0) begin
			chk("write", eq.pop_front(), wq.pop_front());
		end
		adc <= rnd() & 16'h3FFF;
		wr(REG_USER_OFFSET, 16'h0005);
		wr(REG_INPUT_DATUM_INDEX, IIX_LIVE);
		repeat (6) @(posedge clock);
		chk("live", adc + 16'h5, {16'h0, iw});
		wr(REG_USER_OFFSET, 16'h0000);
		foreach (s[k]) s[k] = rnd() & 16'h3FFF;
		wr(REG_SAMPLE_COUNT, 16'(DEPTH));
		wr(REG_SAMPLE_INTERVAL, 16'h000A);
		adc <= s[0];
		wr(REG_MODE, 16'h0001);
		// values change midway between 100 us samples, clear of sync delay
		repeat (1249) @(posedge clock);
		for (int k = 1; k < DEPTH; k++) begin
			adc <= s[k];
			repeat (2500) @(posedge clock);
		end
		wait_rec(1'h0, 3000);
		sum = 0;
		sq = 0;
		mx = 0;
		mn = 65535;
		fa = -1;
		fb = -1;
		foreach (s[k]) begin
			q = s[k];
			if (q > thr && fa < 0) fa = k;
			if (q <= thr && fb < 0) fb = k;
			sum += q;
			sq += q * q;
			if (q > mx) mx = q;
			if (q < mn) mn = q;
			chkix("trace", 16'h8000 | 16'(k), {16'h0, s[k]});
		end
		q = 0;
		while ((q + 1) * (q + 1) <= sq / DEPTH) q++;
		chkix("max", IIX_MAX, 32'(mx));
		chkix("min", IIX_MIN, 32'(mn));
		chkix("rms", IIX_RMS, 32'(q));
		chkix("mean", IIX_MEAN, 32'(sum / DEPTH));
		chkix("pp", IIX_PP, 32'(mx - mn));
		chkix("above", IIX_FIRST_ABOVE, 32'(fa < 0 ? 0 : fa));
		chkix("below", IIX_FIRST_BELOW, 32'(fb < 0 ? 0 : fb));
		wr(REG_MODE, 16'h0301);
		chk("fast", 1, {31'h0, fast});
		rd("status", REG_STATUS, 32'h2);
		repeat (8) @(posedge clock);
		chk("no_start", 0, {31'h0, rec});
		trig <= 1'h1;
		repeat (3) @(posedge clock);
		trig <= 1'h0;
		wait_rec(1'h1, 20);
		wait_rec(1'h0, 5000);
		chk("fast_span", 1, n >= (DEPTH - 1) * 250 && n <= DEPTH * 250 + 100);
		test_done();
	end
endmodule : spim_regs_tb
